// ### verilog/temp_sensor_serial_regs.sv
// Two-wire serial slave, register set, comparators and alarm pins of the temperature sensor.
`timescale 1ns/100ps
`default_nettype none
`include "temp_sensor_regs.svh"

// Contract
// RULE1 - Slave only: clock is only sampled, data line is only pulled low.
// RULE2 - Answer address with upper bits 10010 and low bits from two select pins.
// RULE3 - Temperatures and setpoints are 13-bit two's complement, 0.0625 degC per step.
// RULE4 - Result updates only at conversion end; fast reads see stale data.
// RULE5 - Shutdown stops conversions, clears overheat alarm, disables both alarms.
// RULE6 - Serial interface and register access keep working during shutdown.
// RULE7 - Shutdown takes effect only after a millisecond-scale delay.
// RULE8 - Fault queue needs four consecutive faulty conversions before flags set.
// RULE9 - Register select powers up at zero and holds its last written value.
// RULE10 - Reads clear window alarm per mode; shutdown clears both alarms.
// RULE11 - All selectable registers writable except the temperature result; the code also ignores writes to the identification register.
// RULE12 - Master writes address, select byte, then one or two data bytes.
// RULE13 - Master reads directly, or sets select and uses repeated start.
// RULE14 - Multi-byte registers go out high byte first, each MSB first.
// RULE15 - After the last read byte, acknowledge or no acknowledge both finish cleanly; the code ends the read only on no acknowledge.
// RULE16 - A stop after a partial read may leave the data line pulled low.
// RULE17 - Master clocks out a stuck data line then stops; device returns idle.
// RULE18 - Select codes 0-5 and 7 pick registers; upper select bits stay zero.
// RULE19 - Result word: temperature in bits 15-3, overheat, ceiling, floor flags below.
// RULE20 - Config bit0 shutdown, bit1 event mode, bit4 fault queue, all reset zero.
// RULE21 - Config bits 2 and 3 set alarm polarities, zero meaning active low.
// RULE22 - Master keeps configuration bits 5 to 7 at zero.
// RULE23 - A read aborts the running conversion and restarts it when the read ends.
// RULE24 - Comparator mode: read clears window alarm until next conversion re-evaluates.
// RULE25 - Event mode: read clears window alarm until the next crossing event.
// RULE26 - Conditions clear only past the limit by the return margin.
// RULE27 - Unassigned select code ignores writes and reads back zero.
module temp_sensor_serial_regs #(
  parameter int unsigned CONV_CYCLES = `CONV_TIME_NS / `REF_PERIOD_NS,
  parameter int unsigned SHDN_CYCLES = `SHDN_TIME_NS / `REF_PERIOD_NS,
  // Arbitrary identification value.
  parameter logic [15:0] ID_CODE = `ID_VALUE
) (
  input wire logic ref_clk,
  input wire logic rstn,
  input wire logic scl_i,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe,
  input wire logic addr_select_bit0,
  input wire logic addr_select_bit1,
  input wire temp_sensor_pkg::temp_t meas_temp,
  output logic overheat_alarm_out_o,
  output logic overheat_alarm_out_oe,
  output logic window_alarm_out_o,
  output logic window_alarm_out_oe
);
  import temp_sensor_pkg::*;

  localparam int CW = $clog2(CONV_CYCLES + 1);
  localparam int SW = $clog2(SHDN_CYCLES + 1);

  // ========================================================================
  // Reset release and pin synchronisers
  logic [1:0] rst_sync_ff;
  logic rst_n;
  logic [3:0] pin_meta_ff;
  logic [3:0] pin_ff;
  logic scl_d_ff;
  logic sda_d_ff;
  logic scl_s, sda_s, scl_rise, scl_fall, start_det, stop_det;

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      rst_sync_ff <= 2'h0;
    end else begin
      rst_sync_ff <= {rst_sync_ff[0], 1'b1};
    end
  end
  assign rst_n = rst_sync_ff[1];

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      pin_meta_ff <= 4'hf;
      pin_ff <= 4'hf;
      scl_d_ff <= 1'b1;
      sda_d_ff <= 1'b1;
    end else begin
      pin_meta_ff <= {scl_i, sda_i, addr_select_bit1, addr_select_bit0};
      pin_ff <= pin_meta_ff;
      scl_d_ff <= pin_ff[3];
      sda_d_ff <= pin_ff[2];
    end
  end

  assign scl_s = pin_ff[3];
  assign sda_s = pin_ff[2];
  assign scl_rise = scl_s & ~scl_d_ff; // [RULE1]
  assign scl_fall = ~scl_s & scl_d_ff;
  assign start_det = scl_s & scl_d_ff & sda_d_ff & ~sda_s;
  assign stop_det = scl_s & scl_d_ff & ~sda_d_ff & sda_s;

  // ========================================================================
  // Serial slave state machine
  bus_state_e state_ff;
  logic [3:0] bit_cnt_ff;
  logic [7:0] rx_ff;
  logic [7:0] tx_ff;
  logic [15:0] word_ff;
  logic sel_lo_ff;
  logic sda_oe_ff;
  logic [15:0] rd_word;
  logic rx_done, addr_hit, ptr_we, data_we, rd_start;

  assign rx_done = scl_fall & (bit_cnt_ff == `BIT_ACK) &
                   (state_ff == st_addr || state_ff == st_ptr || state_ff == st_wr);
  assign addr_hit = (rx_ff[7:1] == {`ADDR_FIXED, pin_ff[1], pin_ff[0]}); // [RULE2]
  assign ptr_we = rx_done & (state_ff == st_ptr);
  assign data_we = rx_done & (state_ff == st_wr);
  assign rd_start = rx_done & (state_ff == st_addr) & addr_hit & rx_ff[0]; // [RULE13]

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_ff <= st_idle;
      bit_cnt_ff <= 4'h0;
      rx_ff <= 8'h00;
      tx_ff <= 8'h00;
      word_ff <= 16'h0000;
      sel_lo_ff <= 1'b0;
      sda_oe_ff <= 1'b0;
    end else if (stop_det) begin
      state_ff <= st_idle; // [RULE17]
      sda_oe_ff <= 1'b0;
    end else if (start_det) begin
      state_ff <= st_addr;
      bit_cnt_ff <= 4'h0;
      sda_oe_ff <= 1'b0;
    end else if (scl_rise) begin
      if (bit_cnt_ff != `BIT_ACK) begin
        rx_ff <= {rx_ff[6:0], sda_s};
        bit_cnt_ff <= bit_cnt_ff + 4'h1;
      end else begin
        bit_cnt_ff <= 4'h0;
        if (state_ff == st_rd) begin
          if (sda_s) begin
            state_ff <= st_wait; // [RULE15]
          end else begin
            tx_ff <= sel_lo_ff ? word_ff[7:0] : word_ff[15:8]; // [RULE14]
            sel_lo_ff <= ~sel_lo_ff;
          end
        end
      end
    end else if (scl_fall) begin
      case (state_ff)
        st_addr, st_ptr, st_wr: begin
          if (bit_cnt_ff == `BIT_ACK) begin
            if (state_ff == st_addr && !addr_hit) begin
              state_ff <= st_wait;
            end else begin
              sda_oe_ff <= 1'b1;
            end
            if (rd_start) begin
              tx_ff <= rd_word[15:8]; // [RULE14]
              word_ff <= rd_word;
              sel_lo_ff <= 1'b1;
            end
          end else if (sda_oe_ff) begin
            if (state_ff == st_addr && rx_ff[0]) begin
              state_ff <= st_rd;
              sda_oe_ff <= ~tx_ff[7];
              tx_ff <= {tx_ff[6:0], 1'b0};
            end else begin
              sda_oe_ff <= 1'b0;
              state_ff <= (state_ff == st_addr) ? st_ptr : st_wr; // [RULE12]
            end
          end
        end
        st_rd: begin
          if (bit_cnt_ff != `BIT_ACK) begin
            sda_oe_ff <= ~tx_ff[7]; // [RULE1] [RULE16]
            tx_ff <= {tx_ff[6:0], 1'b0};
          end else begin
            sda_oe_ff <= 1'b0;
          end
        end
        default: begin
        end
      endcase
    end
  end

  assign sda_oe = sda_oe_ff;
  assign sda_o = 1'b0;

  // ========================================================================
  // Register file
  logic [7:0] select_ff;
  logic [7:0] cfg_ff;
  logic signed [12:0] margin_ff, shutdown_ff, floor_ff, ceiling_ff;
  logic [7:0] msb_ff;
  logic wbyte_ff;
  logic signed [12:0] wr_val;
  temp_t temp_ff;
  logic [2:0] flags_ff;

  assign wr_val = {msb_ff, rx_ff[7:`TEMP_LSB]};

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      select_ff <= `SELECT_RST; // [RULE9]
      cfg_ff <= `CFG_RST; // [RULE20] [RULE21]
      margin_ff <= `MARGIN_RST;
      shutdown_ff <= `SHUTDOWN_RST;
      floor_ff <= `FLOOR_RST;
      ceiling_ff <= `CEILING_RST;
      msb_ff <= 8'h00;
      wbyte_ff <= 1'b0;
    end else if (ptr_we) begin
      select_ff <= rx_ff; // [RULE9] [RULE18]
      wbyte_ff <= 1'b0;
    end else if (data_we) begin
      wbyte_ff <= ~wbyte_ff;
      if (!wbyte_ff) begin
        msb_ff <= rx_ff;
      end
      case (select_ff[2:0])
        `SEL_CFG: cfg_ff <= rx_ff; // [RULE6] [RULE22]
        `SEL_MARGIN: if (wbyte_ff) margin_ff <= wr_val; // [RULE3]
        `SEL_SHUTDOWN: if (wbyte_ff) shutdown_ff <= wr_val;
        `SEL_FLOOR: if (wbyte_ff) floor_ff <= wr_val;
        `SEL_CEILING: if (wbyte_ff) ceiling_ff <= wr_val;
        default: begin
        end // [RULE11] [RULE27]
      endcase
    end
  end

  always_comb begin
    case (select_ff[2:0]) // [RULE18]
      `SEL_TEMP: rd_word = {temp_ff, flags_ff}; // [RULE19]
      `SEL_CFG: rd_word = {cfg_ff, cfg_ff};
      `SEL_MARGIN: rd_word = {margin_ff, 3'h0};
      `SEL_SHUTDOWN: rd_word = {shutdown_ff, 3'h0};
      `SEL_FLOOR: rd_word = {floor_ff, 3'h0};
      `SEL_CEILING: rd_word = {ceiling_ff, 3'h0};
      `SEL_ID: rd_word = ID_CODE;
      default: rd_word = 16'h0000; // [RULE27]
    endcase
  end

  // ========================================================================
  // Read tracking, shutdown entry and conversion timing
  logic read_active_ff;
  logic shdn_active_ff;
  logic [SW-1:0] shdn_cnt_ff;
  logic [CW-1:0] conv_cnt_ff;
  logic conv_done;

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      read_active_ff <= 1'b0;
    end else if (rd_start) begin
      read_active_ff <= 1'b1;
    end else if (stop_det || start_det) begin
      read_active_ff <= 1'b0;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      shdn_cnt_ff <= '0;
      shdn_active_ff <= 1'b0;
    end else if (!cfg_ff[`CFG_SHDN]) begin
      shdn_cnt_ff <= '0;
      shdn_active_ff <= 1'b0;
    end else if (!shdn_active_ff) begin
      if (shdn_cnt_ff == SW'(SHDN_CYCLES - 1)) begin
        shdn_active_ff <= 1'b1; // [RULE7]
      end else begin
        shdn_cnt_ff <= shdn_cnt_ff + SW'(1);
      end
    end
  end

  assign conv_done = !read_active_ff && !shdn_active_ff && (conv_cnt_ff == CW'(CONV_CYCLES - 1));

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      conv_cnt_ff <= '0;
    end else if (read_active_ff || shdn_active_ff || conv_done) begin
      conv_cnt_ff <= '0; // [RULE5] [RULE23]
    end else begin
      conv_cnt_ff <= conv_cnt_ff + CW'(1);
    end
  end

  // ========================================================================
  // Comparators with return margin and fault queue
  logic signed [13:0] t_ext, margin_ext;
  logic signed [13:0] lim_ext [3];
  logic [2:0] trip, rel, nxt_flags;
  logic [1:0] q_ff [3];
  logic [1:0] nxt_q [3];

  always_comb begin
    t_ext = {meas_temp[12], meas_temp};
    margin_ext = {margin_ff[12], margin_ff};
    lim_ext[`FLAG_FLOOR] = {floor_ff[12], floor_ff};
    lim_ext[`FLAG_CEILING] = {ceiling_ff[12], ceiling_ff};
    lim_ext[`FLAG_OVERHEAT] = {shutdown_ff[12], shutdown_ff};
    nxt_flags = flags_ff;
    for (int i = 0; i < 3; i++) begin
      nxt_q[i] = q_ff[i];
      if (i == `FLAG_FLOOR) begin
        trip[i] = t_ext < lim_ext[i];
        rel[i] = t_ext > (lim_ext[i] + margin_ext); // [RULE26]
      end else begin
        trip[i] = t_ext > lim_ext[i];
        rel[i] = t_ext < (lim_ext[i] - margin_ext); // [RULE26]
      end
      if (trip[i]) begin
        if (!cfg_ff[`CFG_FQ_EN] || q_ff[i] == `FQ_LAST) begin
          nxt_flags[i] = 1'b1; // [RULE8]
        end
        nxt_q[i] = (q_ff[i] == `FQ_LAST) ? `FQ_LAST : q_ff[i] + 2'h1;
      end else begin
        nxt_q[i] = 2'h0;
      end
      if (rel[i]) begin
        nxt_flags[i] = 1'b0;
      end
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      temp_ff <= `TEMP_RST;
      flags_ff <= 3'h0;
      for (int i = 0; i < 3; i++) begin
        q_ff[i] <= 2'h0;
      end
    end else if (conv_done) begin
      temp_ff <= meas_temp; // [RULE4]
      flags_ff <= nxt_flags;
      for (int i = 0; i < 3; i++) begin
        q_ff[i] <= nxt_q[i];
      end
    end
  end

  // ========================================================================
  // Alarm outputs, open drain: enable pulls the pin low
  logic win_ff;
  logic ot_oe_ff, win_oe_ff;
  logic win_event;

  assign win_event = (nxt_flags[`FLAG_CEILING:`FLAG_FLOOR] != flags_ff[`FLAG_CEILING:`FLAG_FLOOR]);

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      win_ff <= 1'b0;
    end else if (shdn_active_ff) begin
      win_ff <= 1'b0; // [RULE5] [RULE10]
    end else if (!cfg_ff[`CFG_MODE]) begin
      if (conv_done) begin
        win_ff <= nxt_flags[`FLAG_CEILING] | nxt_flags[`FLAG_FLOOR]; // [RULE24]
      end else if (rd_start) begin
        win_ff <= 1'b0; // [RULE10]
      end
    end else begin
      win_ff <= (win_ff & ~rd_start) | (conv_done & win_event); // [RULE25]
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      ot_oe_ff <= 1'b0;
      win_oe_ff <= 1'b0;
    end else begin
      ot_oe_ff <= (flags_ff[`FLAG_OVERHEAT] & ~shdn_active_ff) ^ cfg_ff[`CFG_OT_POL]; // [RULE5]
      win_oe_ff <= win_ff ^ cfg_ff[`CFG_WIN_POL]; // [RULE21]
    end
  end

  assign overheat_alarm_out_oe = ot_oe_ff;
  assign window_alarm_out_oe = win_oe_ff;
  assign overheat_alarm_out_o = 1'b0;
  assign window_alarm_out_o = 1'b0;

  // ========================================================================
  // Assertions
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);

  property p_oe_on_fall;
    $rose(sda_oe_ff) |-> $past(scl_fall);
  endproperty
  a_oe_on_fall: assert property (p_oe_on_fall) else $error("data pulled low off a clock fall"); // [RULE1]

  property p_addr_miss;
    (rx_done && state_ff == st_addr && !addr_hit) |=> (state_ff == st_wait) && !sda_oe_ff;
  endproperty
  a_addr_miss: assert property (p_addr_miss) else $error("foreign address acknowledged"); // [RULE2]

  property p_select_hold;
    !ptr_we |=> $stable(select_ff);
  endproperty
  a_select_hold: assert property (p_select_hold) else $error("select changed without write"); // [RULE9]

  property p_temp_hold;
    !conv_done |=> $stable(temp_ff);
  endproperty
  a_temp_hold: assert property (p_temp_hold) else $error("result changed outside conversion"); // [RULE4]

  property p_shdn_quiet;
    shdn_active_ff ##1 shdn_active_ff |=> !win_ff && (ot_oe_ff == cfg_ff[`CFG_OT_POL]);
  endproperty
  a_shdn_quiet: assert property (p_shdn_quiet) else $error("alarm active in shutdown"); // [RULE5]

  property p_read_halts;
    read_active_ff |=> conv_cnt_ff == '0;
  endproperty
  a_read_halts: assert property (p_read_halts) else $error("conversion ran during read"); // [RULE23]

  property p_read_clears;
    (rd_start && !conv_done && !shdn_active_ff) |=> !win_ff;
  endproperty
  a_read_clears: assert property (p_read_clears) else $error("read left window alarm set"); // [RULE10]

  property p_nack_ends;
    (state_ff == st_rd && scl_rise && bit_cnt_ff == `BIT_ACK && sda_s && !stop_det && !start_det)
      |=> state_ff == st_wait ##1 !sda_oe_ff;
  endproperty
  a_nack_ends: assert property (p_nack_ends) else $error("no acknowledge not honoured"); // [RULE15]

  property p_stop_idle;
    stop_det |=> (state_ff == st_idle) && !sda_oe_ff;
  endproperty
  a_stop_idle: assert property (p_stop_idle) else $error("stop did not return to idle"); // [RULE17]

  property p_shdn_delay;
    $rose(shdn_active_ff) |-> $past(cfg_ff[`CFG_SHDN]) && $past(shdn_cnt_ff) == SW'(SHDN_CYCLES - 1);
  endproperty
  a_shdn_delay: assert property (p_shdn_delay) else $error("shutdown entered early"); // [RULE7]

  c_read: cover property (rd_start);
  c_write_setpoint: cover property (data_we && wbyte_ff);
  c_shutdown: cover property ($rose(shdn_active_ff));
  c_window_alarm: cover property ($rose(win_ff));

endmodule // temp_sensor_serial_regs
`default_nettype wire

// ### verilog/temp_sensor_regs.svh
// Register map, field positions, reset values and timing constants of the sensor register set.
`ifndef TEMP_SENSOR_REGS_SVH
`define TEMP_SENSOR_REGS_SVH

// ==========================================================================
// Slave address
`define ADDR_FIXED 5'h12

// ==========================================================================
// Register select codes (low three bits of the select register)
`define SEL_TEMP 3'h0
`define SEL_CFG 3'h1
`define SEL_MARGIN 3'h2
`define SEL_SHUTDOWN 3'h3
`define SEL_FLOOR 3'h4
`define SEL_CEILING 3'h5
`define SEL_UNUSED 3'h6
`define SEL_ID 3'h7
`define SELECT_RST 8'h00

// ==========================================================================
// Configuration fields
`define CFG_SHDN 0
`define CFG_MODE 1
`define CFG_OT_POL 2
`define CFG_WIN_POL 3
`define CFG_FQ_EN 4
`define CFG_RST 8'h00

// ==========================================================================
// Temperature word layout and setpoint defaults (0.0625 degC per step)
`define TEMP_LSB 3
`define FLAG_FLOOR 0
`define FLAG_CEILING 1
`define FLAG_OVERHEAT 2
`define TEMP_RST 13'h0000
`define MARGIN_RST 13'h0020
`define FLOOR_RST 13'h00a0
`define CEILING_RST 13'h0400
`define SHUTDOWN_RST 13'h0500

// Arbitrary identification value.
`define ID_VALUE 16'h5a01

// ==========================================================================
// Serial framing and timing
`define BIT_ACK 4'h8
`define FQ_LAST 2'h3
`define REF_PERIOD_NS 5
`define CONV_TIME_NS 100000000
`define SHDN_TIME_NS 1000000

`endif

// ### verilog/temp_sensor_pkg.sv
// Types shared by the temperature sensor register block.
`default_nettype none
package temp_sensor_pkg;
  typedef logic signed [12:0] temp_t;
  typedef enum logic [2:0] {st_idle, st_addr, st_ptr, st_wr, st_rd, st_wait} bus_state_e;
endpackage
`default_nettype wire

// ### dv/bus_master_model.sv
// Two-wire bus master model that drives the sensor's bus pins.
`timescale 1ns/100ps
`default_nettype none
module bus_master_model (
  input wire logic ref_clk,
  input wire logic sda_oe,
  input wire logic sda_o,
  output logic scl,
  output logic sda
);
  logic scl_q = 1'b1;
  logic sda_q = 1'b1;
  // The pulled-up data line is low when either party pulls it.
  assign scl = scl_q;
  assign sda = sda_oe ? (sda_q & sda_o) : sda_q;
  // Frames start off the clock edge so that no bus edge meets a sampling edge.
  task automatic align();
    @(posedge ref_clk);
    #1.5;
  endtask
  task automatic start_c();
    sda_q = 1'b1;
    #12 scl_q = 1'b1;
    #12 sda_q = 1'b0;
    #12 scl_q = 1'b0;
    #12;
  endtask
  task automatic stop_c();
    sda_q = 1'b0;
    #12 scl_q = 1'b1;
    #12 sda_q = 1'b1;
    #12;
  endtask
  task automatic bit_c(input logic d, output logic s);
    sda_q = d;
    #12 scl_q = 1'b1;
    #12 s = sda;
    #12 scl_q = 1'b0;
    #12;
  endtask
  task automatic wr_byte(input logic [7:0] b, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      bit_c(b[i], s);
    end
    bit_c(1'b1, s);
    ack = !s;
  endtask
  // A refused last byte lets the device release the data line.
  task automatic rd_byte(output logic [7:0] b, input logic last);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      bit_c(1'b1, s);
      b[i] = s;
    end
    bit_c(last, s);
  endtask
endmodule // bus_master_model
`default_nettype wire

// ### dv/test_temp_sensor_serial_regs.sv
// Self-checking bench for the sensor's serial register block.
`timescale 1ns/100ps
`default_nettype none
module test_temp_sensor_serial_regs;
  import temp_sensor_pkg::*;
  localparam int CONV = 200;
  localparam int SHDN = 40;
  // Arbitrary identification value.
  localparam logic [15:0] ID = 16'h3c5a;
  localparam logic [6:0] DEV = {5'h12, 2'b10};
  localparam logic [15:0] DFLT [8] = '{16'h0, 16'h0, 16'h0100, 16'h2800, 16'h0500,
                                       16'h2000, 16'h0, ID};
  logic ref_clk = 1'b0;
  logic rstn = 1'b0;
  logic [1:0] addr_sel = 2'b10;
  temp_t meas_temp = 13'h0190;
  logic scl;
  logic sda;
  logic sda_oe;
  logic sda_o;
  logic ot_o;
  logic win_o;
  logic ot_oe;
  logic win_oe;
  int n_fail = 0;
  int cmp_count = 0;

  always #2.5 ref_clk = ~ref_clk;

  // ==========================
  // Design and bus master
  temp_sensor_serial_regs #(.CONV_CYCLES(CONV), .SHDN_CYCLES(SHDN), .ID_CODE(ID)) uut (
    .ref_clk(ref_clk), .rstn(rstn), .scl_i(scl), .sda_i(sda), .sda_o(sda_o), .sda_oe(sda_oe),
    .addr_select_bit0(addr_sel[0]), .addr_select_bit1(addr_sel[1]), .meas_temp(meas_temp),
    .overheat_alarm_out_o(ot_o), .overheat_alarm_out_oe(ot_oe),
    .window_alarm_out_o(win_o), .window_alarm_out_oe(win_oe));
  bus_master_model m (.ref_clk(ref_clk), .sda_oe(sda_oe), .sda_o(sda_o), .scl(scl), .sda(sda));

  // ==========================
  // Shared tasks
  task automatic finish_test();
    $display("comparisons %0d mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    cmp_count++;
    if (got !== exp) begin
      n_fail++;
      $display("CHECK FAILED t=%0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge ref_clk);
    #1.5;
  endtask
  task automatic probe(input logic [6:0] ad, input logic exp);
    logic a;
    m.align();
    m.start_c();
    m.wr_byte({ad, 1'b0}, a);
    m.stop_c();
    check(a, exp);
  endtask
  task automatic wr_reg(input logic [7:0] ptr, input logic [15:0] d, input int n);
    logic a;
    m.align();
    m.start_c();
    m.wr_byte({DEV, 1'b0}, a);
    m.wr_byte(ptr, a);
    for (int i = n - 1; i >= 0; i--) begin
      m.wr_byte(d[8*i +: 8], a);
    end
    m.stop_c();
  endtask
  task automatic rd_reg(input logic [7:0] ptr, input bit setp, input int n,
                        output logic [15:0] w);
    logic a;
    logic [7:0] b;
    w = '0;
    m.align();
    m.start_c();
    if (setp) begin
      m.wr_byte({DEV, 1'b0}, a);
      m.wr_byte(ptr, a);
      m.start_c();
    end
    m.wr_byte({DEV, 1'b1}, a);
    for (int i = 0; i < n; i++) begin
      m.rd_byte(b, i == n - 1);
      w = {w[7:0], b};
    end
    m.stop_c();
  endtask

  // ==========================
  // Scenarios
  task automatic t_reset();
    logic [15:0] w;
    rd_reg(8'h00, 1'b0, 2, w);
    check(w, 16'h0000);
    for (int p = 1; p < 8; p++) begin
      rd_reg(8'(p), 1'b1, (p == 1) ? 1 : 2, w);
      check(w & ((p > 1 && p < 6) ? 16'hfff8 : 16'hffff), DFLT[p]);
    end
  endtask
  task automatic t_addr();
    probe({5'h12, 2'b01}, 1'b0);
    probe({5'h13, 2'b10}, 1'b0);
    cyc(1);
    addr_sel = 2'b01;
    cyc(8);
    probe({5'h12, 2'b01}, 1'b1);
    addr_sel = 2'b10;
    cyc(8);
  endtask
  task automatic t_write();
    logic [15:0] w;
    logic [15:0] v [2:5] = '{16'h0180, 16'h3000, 16'h0280, 16'h2400};
    logic [7:0] ro [3] = '{8'h00, 8'h06, 8'h07};
    logic [15:0] re [3] = '{16'h0c80, 16'h0000, ID};
    for (int p = 2; p < 6; p++) begin
      wr_reg(8'(p), v[p] | 16'h0005, 2);
      rd_reg(8'(p), 1'b1, 2, w);
      check(w & 16'hfff8, v[p]);
    end
    wr_reg(8'h01, 16'h001e, 1);
    rd_reg(8'h01, 1'b1, 1, w);
    check(w, 16'h001e);
    wr_reg(8'h01, 16'h0000, 1);
    for (int i = 0; i < 3; i++) begin
      wr_reg(ro[i], 16'hffff, 2);
      rd_reg(ro[i], 1'b1, 2, w);
      check(w, re[i]);
    end
  endtask
  task automatic t_alarm();
    logic [15:0] w;
    cyc(1);
    meas_temp = 13'h0620;
    cyc(2 * CONV + 20);
    check({ot_oe, win_oe}, 2'b11);
    check({ot_o, win_o}, 2'b00);
    rd_reg(8'h00, 1'b1, 2, w);
    check(w, 16'h3106);
    check({ot_oe, win_oe}, 2'b10);
    cyc(CONV + 20);
    check(win_oe, 1'b1);
    meas_temp = 13'h0460;
    cyc(CONV + 20);
    rd_reg(8'h00, 1'b1, 2, w);
    check(w, 16'h2302);
    meas_temp = 13'h0440;
    cyc(CONV + 20);
    rd_reg(8'h00, 1'b1, 2, w);
    check(w, 16'h2200);
    meas_temp = 13'h0620;
    cyc(CONV + 20);
    wr_reg(8'h01, 16'h000c, 1);
    cyc(2);
    check({ot_oe, win_oe}, 2'b00);
    wr_reg(8'h01, 16'h0000, 1);
  endtask
  task automatic t_fault();
    logic [15:0] w;
    cyc(1);
    meas_temp = 13'h0190;
    cyc(2 * CONV + 20);
    wr_reg(8'h01, 16'h0010, 1);
    rd_reg(8'h00, 1'b1, 2, w);
    cyc(1);
    meas_temp = 13'h0620;
    cyc(3 * CONV + CONV / 2);
    check(ot_oe, 1'b0);
    cyc(CONV);
    check(ot_oe, 1'b1);
    wr_reg(8'h01, 16'h0000, 1);
  endtask
  task automatic t_shdn();
    logic [15:0] w;
    wr_reg(8'h01, 16'h0001, 1);
    check(ot_oe, 1'b1);
    cyc(SHDN + 10);
    check({ot_oe, win_oe}, 2'b00);
    meas_temp = 13'h0100;
    wr_reg(8'h02, 16'h0200, 2);
    cyc(2 * CONV);
    rd_reg(8'h02, 1'b1, 2, w);
    check(w & 16'hfff8, 16'h0200);
    rd_reg(8'h00, 1'b1, 2, w);
    check(w & 16'hfff8, 16'h3100);
    wr_reg(8'h01, 16'h0000, 1);
    cyc(CONV + 20);
    rd_reg(8'h00, 1'b1, 2, w);
    check(w, 16'h0800);
  endtask
  task automatic t_stale();
    logic [15:0] w;
    rd_reg(8'h00, 1'b0, 1, w);
    check(w, 16'h0008);
    cyc(1);
    meas_temp = 13'h0200;
    for (int i = 0; i < 3; i++) begin
      rd_reg(8'h00, 1'b0, 2, w);
      check(w, 16'h0800);
    end
    cyc(CONV + 20);
    rd_reg(8'h00, 1'b0, 2, w);
    check(w, 16'h1000);
  endtask

  // ==========================
  // Event mode: a read clears the window alarm, only a new crossing sets it again.
  task automatic t_event();
    logic [15:0] w;
    wr_reg(8'h01, 16'h0002, 1);
    cyc(1);
    meas_temp = 13'h0040;
    cyc(CONV + 20);
    check(win_oe, 1'b1);
    rd_reg(8'h00, 1'b1, 2, w);
    check(w, 16'h0201);
    check(win_oe, 1'b0);
    cyc(CONV + 20);
    check(win_oe, 1'b0);
    meas_temp = 13'h00a0;
    cyc(CONV + 20);
    check(win_oe, 1'b1);
    rd_reg(8'h00, 1'b1, 2, w);
    check(w, 16'h0500);
    wr_reg(8'h01, 16'h0000, 1);
  endtask

  // ==========================
  // Main sequence and watchdog
  initial begin
    repeat (2) @(posedge ref_clk);
    #1.5;
    rstn = 1'b1;
    cyc(8);
    t_reset();
    t_addr();
    t_write();
    t_alarm();
    t_fault();
    t_shdn();
    t_stale();
    t_event();
    finish_test();
  end
  initial begin
    #400000;
    n_fail++;
    finish_test();
  end
endmodule // test_temp_sensor_serial_regs
`default_nettype wire
